// file: hdl/clock_gen_control_logic.sv
// control logic of a multi-output clock generator: two-wire configuration slave,
// stop-clock gating for processor, interrupt-controller, memory and bus clocks,
// and power-up strap capture on the shared pins.
// assumes i_clock is the internal processor clock and i_bus_clock the bus clock;
// i_rst is the power-on reset, held for at least three i_clock edges.
`timescale 1ns/1ps
module clock_gen_control_logic #(
	parameter int NUM_BUS_CLOCKS = clock_gen_pkg::GATED_BUS_CLOCKS,
	parameter int NUM_STRAPS = clock_gen_pkg::STRAP_WIDTH
) (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_bus_clock,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda,
	output logic o_sda_oe_n,
	input wire logic i_proc_clock_halt_alias_n,
	input wire logic i_bus_clock_halt_n,
	input wire logic i_mem_buffer_in,
	input wire logic [NUM_STRAPS-1:0] i_shared_pin,
	input wire logic [NUM_STRAPS-1:0] i_shared_clock_src,
	output logic [NUM_STRAPS-1:0] o_shared_pin,
	output logic [NUM_STRAPS-1:0] o_shared_pin_oe_n,
	output logic [NUM_STRAPS-1:0] o_freq_select_strap,
	output logic o_processor_clock_out,
	output logic o_intr_ctrl_clock_out,
	output logic o_gated_mem_clock,
	output logic o_free_mem_clock,
	output logic [NUM_BUS_CLOCKS-1:0] o_gated_bus_clocks,
	output logic o_free_bus_clock
);
	// link pin synchronisers: first stage is read only by the second
	logic scl_s1_reg;
	logic scl_s2_reg;
	logic scl_d_reg;
	logic sda_s1_reg;
	logic sda_s2_reg;
	logic sda_d_reg;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;

	clock_gen_pkg::link_state_type state_reg;
	clock_gen_pkg::link_state_type state_next;
	logic [7:0] rx_shift_reg;
	logic [7:0] tx_shift_reg;
	logic [3:0] bit_cnt_reg;
	logic [3:0] seq_reg;
	logic is_read_reg;
	logic host_ack_reg;
	logic sda_low_reg;
	logic [7:0] cfg_reg [clock_gen_pkg::CONFIG_BYTES];
	logic [7:0] rd_byte;
	logic wr_strobe;

	always_ff @(posedge i_clock) begin
		scl_s1_reg <= i_scl;
		scl_s2_reg <= scl_s1_reg;
		scl_d_reg <= scl_s2_reg;
		sda_s1_reg <= i_sda;
		sda_s2_reg <= sda_s1_reg;
		sda_d_reg <= sda_s2_reg;
	end

	assign scl_rise = scl_s2_reg & ~scl_d_reg;
	assign scl_fall = ~scl_s2_reg & scl_d_reg;
	assign start_seen = scl_s2_reg & scl_d_reg & sda_d_reg & ~sda_s2_reg;
	assign stop_seen = scl_s2_reg & scl_d_reg & ~sda_d_reg & sda_s2_reg;

	// read answer: byte count first, then latches in ascending order
	always_comb begin
		rd_byte = clock_gen_pkg::FILLER_BYTE;
		if (seq_reg == 4'h0) begin
			rd_byte = clock_gen_pkg::BYTE_COUNT_VALUE;
		end else if (seq_reg <= 4'(clock_gen_pkg::CONFIG_BYTES)) begin
			rd_byte = cfg_reg[3'(seq_reg - 4'h1)];
		end
	end

	// link state machine; every byte is eight bits wide
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			clock_gen_pkg::LINK_IDLE: begin
			end
			clock_gen_pkg::LINK_ADDR: begin
				if (scl_fall && bit_cnt_reg == clock_gen_pkg::BYTE_BITS_CNT) begin
					if (rx_shift_reg == clock_gen_pkg::WRITE_ADDR
						|| rx_shift_reg == clock_gen_pkg::READ_ADDR) begin
						state_next = clock_gen_pkg::LINK_ADDR_ACK;
					end else begin
						state_next = clock_gen_pkg::LINK_IDLE;
					end
				end
			end
			clock_gen_pkg::LINK_ADDR_ACK: begin
				if (scl_fall) begin
					state_next = is_read_reg ? clock_gen_pkg::LINK_RD_BYTE
						: clock_gen_pkg::LINK_WR_BYTE;
				end
			end
			clock_gen_pkg::LINK_WR_BYTE: begin
				if (scl_fall && bit_cnt_reg == clock_gen_pkg::BYTE_BITS_CNT) begin
					state_next = clock_gen_pkg::LINK_WR_ACK;
				end
			end
			clock_gen_pkg::LINK_WR_ACK: begin
				if (scl_fall) begin
					state_next = clock_gen_pkg::LINK_WR_BYTE;
				end
			end
			clock_gen_pkg::LINK_RD_BYTE: begin
				if (scl_fall && bit_cnt_reg[2:0] == clock_gen_pkg::LAST_BIT) begin
					state_next = clock_gen_pkg::LINK_RD_ACK;
				end
			end
			clock_gen_pkg::LINK_RD_ACK: begin
				if (scl_fall) begin
					// a missing acknowledge ends the read; the host then stops
					state_next = host_ack_reg ? clock_gen_pkg::LINK_RD_BYTE
						: clock_gen_pkg::LINK_IDLE;
				end
			end
			default: begin
				state_next = clock_gen_pkg::LINK_IDLE;
			end
		endcase
		if (start_seen) begin
			state_next = clock_gen_pkg::LINK_ADDR;
		end else if (stop_seen) begin
			state_next = clock_gen_pkg::LINK_IDLE;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			state_reg <= clock_gen_pkg::LINK_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// receive shift and bit counting on clock rise; read bits counted on clock fall
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			bit_cnt_reg <= 4'h0;
			rx_shift_reg <= 8'h00;
		end else if (start_seen) begin
			bit_cnt_reg <= 4'h0;
		end else if (state_reg == clock_gen_pkg::LINK_RD_BYTE) begin
			if (scl_fall) begin
				bit_cnt_reg <= (bit_cnt_reg[2:0] == clock_gen_pkg::LAST_BIT) ? 4'h0
					: bit_cnt_reg + 4'h1;
			end
		end else if (state_reg == clock_gen_pkg::LINK_ADDR
			|| state_reg == clock_gen_pkg::LINK_WR_BYTE) begin
			if (scl_rise && bit_cnt_reg != clock_gen_pkg::BYTE_BITS_CNT) begin
				rx_shift_reg <= {rx_shift_reg[6:0], sda_s2_reg};
				bit_cnt_reg <= bit_cnt_reg + 4'h1;
			end else if (scl_fall && bit_cnt_reg == clock_gen_pkg::BYTE_BITS_CNT) begin
				bit_cnt_reg <= 4'h0;
			end
		end else begin
			bit_cnt_reg <= 4'h0;
		end
	end

	// direction, byte sequence and host acknowledge
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			is_read_reg <= 1'b0;
			seq_reg <= 4'h0;
			host_ack_reg <= 1'b0;
		end else begin
			if (state_reg == clock_gen_pkg::LINK_ADDR && state_next
				== clock_gen_pkg::LINK_ADDR_ACK) begin
				is_read_reg <= rx_shift_reg == clock_gen_pkg::READ_ADDR;
				seq_reg <= 4'h0;
			end else if (state_reg == clock_gen_pkg::LINK_WR_BYTE
				&& state_next == clock_gen_pkg::LINK_WR_ACK
				&& seq_reg != clock_gen_pkg::SEQ_LIMIT) begin
				seq_reg <= seq_reg + 4'h1;
			end else if (state_reg == clock_gen_pkg::LINK_RD_BYTE
				&& state_next == clock_gen_pkg::LINK_RD_ACK
				&& seq_reg != clock_gen_pkg::SEQ_LIMIT) begin
				// advance before the acknowledge so the next byte is ready at its fall
				seq_reg <= seq_reg + 4'h1;
			end
			if (state_reg == clock_gen_pkg::LINK_RD_ACK && scl_rise) begin
				host_ack_reg <= ~sda_s2_reg;
			end
		end
	end

	// transmit shift: new bit placed just after the clock falls
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			tx_shift_reg <= 8'h00;
		end else if ((state_reg == clock_gen_pkg::LINK_ADDR_ACK
			|| state_reg == clock_gen_pkg::LINK_RD_ACK) && scl_fall) begin
			tx_shift_reg <= rd_byte;
		end else if (state_reg == clock_gen_pkg::LINK_RD_BYTE && scl_fall) begin
			tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
		end
	end

	// data line drive: acknowledges and read data zeros only
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			sda_low_reg <= 1'b0;
		end else if (start_seen || stop_seen) begin
			sda_low_reg <= 1'b0;
		end else begin
			unique case (state_next)
				clock_gen_pkg::LINK_ADDR_ACK,
				clock_gen_pkg::LINK_WR_ACK: begin
					sda_low_reg <= 1'b1;
				end
				clock_gen_pkg::LINK_RD_BYTE: begin
					if (scl_fall) begin
						sda_low_reg <= (state_reg == clock_gen_pkg::LINK_RD_BYTE)
							? ~tx_shift_reg[6] : ~rd_byte[7];
					end
				end
				default: begin
					sda_low_reg <= 1'b0;
				end
			endcase
		end
	end

	assign o_sda = 1'b0;
	assign o_sda_oe_n = ~sda_low_reg;

	// only block writes exist: command and count are dropped by position
	assign wr_strobe = state_reg == clock_gen_pkg::LINK_WR_BYTE
		&& state_next == clock_gen_pkg::LINK_WR_ACK
		&& seq_reg >= clock_gen_pkg::SEQ_FIRST_DATA;

	genvar gi;
	generate
		for (gi = 0; gi < clock_gen_pkg::CONFIG_BYTES; gi++) begin : g_cfg
			always_ff @(posedge i_clock) begin
				if (i_rst) begin
					cfg_reg[gi] <= clock_gen_pkg::CFG_DEFAULT;
				end else if (wr_strobe
					&& seq_reg == 4'(gi) + clock_gen_pkg::SEQ_FIRST_DATA) begin
					// only the addressed latch moves, so a short block leaves the rest
					cfg_reg[gi] <= rx_shift_reg;
				end
			end
		end
	endgenerate

	// processor-side stop clock
	logic proc_halt_s1_reg;
	logic proc_halt_s2_reg;
	logic proc_en_reg;
	logic intr_en_reg;
	logic mem_en_reg;

	always_ff @(posedge i_clock) begin
		proc_halt_s1_reg <= i_proc_clock_halt_alias_n;
		proc_halt_s2_reg <= proc_halt_s1_reg;
	end

	// enables change while the clock is low, so gated outputs never clip a pulse;
	// sync plus half a period keeps latency under four periods
	always_ff @(negedge i_clock) begin
		if (i_rst) begin
			proc_en_reg <= 1'b0;
			intr_en_reg <= 1'b0;
			mem_en_reg <= 1'b0;
		end else begin
			proc_en_reg <= proc_halt_s2_reg
				& cfg_reg[clock_gen_pkg::CLOCK_ENABLE_BYTE][clock_gen_pkg::PROC_ENABLE_BIT];
			intr_en_reg <= proc_halt_s2_reg
				& cfg_reg[clock_gen_pkg::CLOCK_ENABLE_BYTE][clock_gen_pkg::INTR_ENABLE_BIT];
			mem_en_reg <= proc_halt_s2_reg
				& cfg_reg[clock_gen_pkg::CLOCK_ENABLE_BYTE][clock_gen_pkg::MEM_ENABLE_BIT];
		end
	end

	assign o_processor_clock_out = i_clock & proc_en_reg;
	assign o_intr_ctrl_clock_out = i_clock & intr_en_reg;
	// gated memory clock is taken from the processor clock so it stops in step
	assign o_gated_mem_clock = i_clock & mem_en_reg;
	assign o_free_mem_clock = i_mem_buffer_in;

	// bus clock domain: reset and enables cross by two flops each
	logic bus_rst_s1_reg;
	logic bus_rst_s2_reg;
	logic bus_halt_s1_reg;
	logic bus_halt_s2_reg;
	logic [NUM_BUS_CLOCKS-1:0] bus_cfg_s1_reg;
	logic [NUM_BUS_CLOCKS-1:0] bus_cfg_s2_reg;
	logic [NUM_BUS_CLOCKS-1:0] bus_en_reg;

	always_ff @(posedge i_bus_clock) begin
		bus_rst_s1_reg <= i_rst;
		bus_rst_s2_reg <= bus_rst_s1_reg;
		bus_halt_s1_reg <= i_bus_clock_halt_n;
		bus_halt_s2_reg <= bus_halt_s1_reg;
		// configuration is quasi-static; a bit-by-bit crossing is enough
		bus_cfg_s1_reg <= cfg_reg[clock_gen_pkg::BUS_ENABLE_BYTE][NUM_BUS_CLOCKS-1:0];
		bus_cfg_s2_reg <= bus_cfg_s1_reg;
	end

	generate
		for (gi = 0; gi < NUM_BUS_CLOCKS; gi++) begin : g_bus
			always_ff @(negedge i_bus_clock) begin
				if (bus_rst_s2_reg) begin
					bus_en_reg[gi] <= 1'b0;
				end else begin
					bus_en_reg[gi] <= bus_halt_s2_reg & bus_cfg_s2_reg[gi];
				end
			end
			assign o_gated_bus_clocks[gi] = i_bus_clock & bus_en_reg[gi];
		end
	endgenerate

	assign o_free_bus_clock = i_bus_clock;

	// power-up straps on the shared pins
	logic [NUM_STRAPS-1:0] strap_s1_reg;
	logic [NUM_STRAPS-1:0] strap_s2_reg;
	logic [NUM_STRAPS-1:0] strap_reg;
	logic strap_done_reg;

	always_ff @(posedge i_clock) begin
		strap_s1_reg <= i_shared_pin;
		strap_s2_reg <= strap_s1_reg;
	end

	// captured on the first edge after reset, never under reset itself
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			strap_done_reg <= 1'b0;
			strap_reg <= '0;
		end else if (!strap_done_reg) begin
			strap_reg <= ~strap_s2_reg;
			strap_done_reg <= 1'b1;
		end
	end

	assign o_freq_select_strap = strap_reg;
	assign o_shared_pin_oe_n = {NUM_STRAPS{~strap_done_reg}};
	assign o_shared_pin = strap_done_reg ? i_shared_clock_src : '0;
endmodule

// file: common/clock_gen_pkg.sv
// constants, field layout and state codes for the clock generator control logic
// assumes a single internal processor clock plus a separate bus clock domain
package clock_gen_pkg;
	// serial link
	localparam logic [7:0] WRITE_ADDR = 8'hd2;
	localparam logic [7:0] READ_ADDR = 8'hd3;
	localparam int LINK_MAX_BIT_RATE_HZ = 100000;
	localparam int BYTE_BITS = 8;
	localparam logic [3:0] BYTE_BITS_CNT = 4'h8;
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam int CONFIG_BYTES = 6;
	localparam logic [7:0] BYTE_COUNT_VALUE = 8'h06;
	localparam logic [7:0] FILLER_BYTE = 8'h00;
	// write sequence: command code, byte count, then data
	localparam logic [3:0] SEQ_FIRST_DATA = 4'h2;
	localparam logic [3:0] SEQ_LIMIT = 4'hf;
	// configuration latches
	localparam logic [7:0] CFG_DEFAULT = 8'hff;
	localparam int BUS_ENABLE_BYTE = 0;
	localparam int CLOCK_ENABLE_BYTE = 1;
	localparam int PROC_ENABLE_BIT = 0;
	localparam int INTR_ENABLE_BIT = 1;
	localparam int MEM_ENABLE_BIT = 2;
	// clock outputs and straps
	localparam int GATED_BUS_CLOCKS = 5;
	localparam int STRAP_WIDTH = 5;
	localparam int PROC_HALT_MIN_HIGH_PERIODS = 100;
	localparam int BUS_HALT_MIN_HIGH_PERIODS = 10;
	localparam int PROC_LATENCY_MAX_PERIODS = 4;
	typedef enum logic [2:0] {
		LINK_IDLE = 3'h0,
		LINK_ADDR = 3'h1,
		LINK_ADDR_ACK = 3'h3,
		LINK_WR_BYTE = 3'h2,
		LINK_WR_ACK = 3'h6,
		LINK_RD_BYTE = 3'h7,
		LINK_RD_ACK = 3'h5
	} link_state_type;
endpackage

// file: dv/serial_host_model.sv
// host model of the two-wire link: start, stop and nine-bit transfers
// assumes the bench resolves the data wire as a pulled-up wired and
`timescale 1ns/1ps
module serial_host_model #(
	parameter int HALF = 128
) (
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda
);
	// clock stands high between frames; the rate is scaled up to keep runs short
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end
	task automatic start();
		#(HALF / 2);
		o_sda = 1'b1;
		#(HALF / 2);
		o_scl = 1'b1;
		#HALF;
		o_sda = 1'b0;
		#HALF;
		o_scl = 1'b0;
	endtask
	task automatic stop();
		#(HALF / 2);
		o_sda = 1'b0;
		#(HALF / 2);
		o_scl = 1'b1;
		#HALF;
		o_sda = 1'b1;
		#HALF;
	endtask
	// data moves mid-low so it never changes near a clock edge
	task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--) begin
			#(HALF / 2);
			o_sda = tx[i];
			#(HALF / 2);
			o_scl = 1'b1;
			#HALF;
			rx[i] = i_sda;
			o_scl = 1'b0;
		end
	endtask
endmodule

// file: dv/clock_gen_control_logic_chk.sv
// assertions on the control logic, from its ports only
// assumes gated clocks are judged at falling edges, where the high phase shows
`timescale 1ns/1ps
module clock_gen_control_logic_chk #(
	parameter int NUM_BUS_CLOCKS = 5,
	parameter int NUM_STRAPS = 5
) (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_bus_clock,
	input wire logic i_scl,
	input wire logic i_proc_clock_halt_alias_n,
	input wire logic i_bus_clock_halt_n,
	input wire logic i_mem_buffer_in,
	input wire logic [NUM_STRAPS-1:0] i_shared_pin,
	input wire logic o_sda_oe_n,
	input wire logic [NUM_STRAPS-1:0] o_shared_pin_oe_n,
	input wire logic [NUM_STRAPS-1:0] o_freq_select_strap,
	input wire logic o_processor_clock_out,
	input wire logic o_intr_ctrl_clock_out,
	input wire logic o_free_mem_clock,
	input wire logic [NUM_BUS_CLOCKS-1:0] o_gated_bus_clocks
);
	property p_proc_off;
		@(negedge i_clock) disable iff (i_rst)
		$fell(i_proc_clock_halt_alias_n) |-> ##[1:4] !o_processor_clock_out;
	endproperty
	a_proc_off: assert property (p_proc_off)
		else $error("processor clock stopped late");
	property p_proc_on;
		@(negedge i_clock) disable iff (i_rst)
		$rose(i_proc_clock_halt_alias_n) |-> ##[1:4] o_processor_clock_out;
	endproperty
	a_proc_on: assert property (p_proc_on)
		else $error("processor clock resumed late");
	property p_proc_held;
		@(negedge i_clock) disable iff (i_rst)
		!i_proc_clock_halt_alias_n [*5] |-> !o_processor_clock_out;
	endproperty
	a_proc_held: assert property (p_proc_held)
		else $error("processor clock toggled while halted");
	property p_intr_held;
		@(negedge i_clock) disable iff (i_rst)
		!i_proc_clock_halt_alias_n [*5] |-> !o_intr_ctrl_clock_out;
	endproperty
	a_intr_held: assert property (p_intr_held)
		else $error("interrupt controller clock toggled while halted");
	property p_bus_off;
		@(negedge i_bus_clock) disable iff (i_rst)
		$fell(i_bus_clock_halt_n) |-> ##[1:3] (o_gated_bus_clocks == '0);
	endproperty
	a_bus_off: assert property (p_bus_off)
		else $error("bus clocks stopped late");
	property p_bus_on;
		@(negedge i_bus_clock) disable iff (i_rst)
		$rose(i_bus_clock_halt_n) |-> ##[1:3] (&o_gated_bus_clocks);
	endproperty
	a_bus_on: assert property (p_bus_on)
		else $error("bus clocks resumed late");
	property p_sda_stable;
		@(posedge i_clock) disable iff (i_rst)
		$changed(o_sda_oe_n) |-> !i_scl;
	endproperty
	a_sda_stable: assert property (p_sda_stable)
		else $error("data line moved while serial clock high");
	property p_strap;
		@(posedge i_clock) disable iff (i_rst)
		$fell(i_rst) |=> (o_shared_pin_oe_n == '0) && (o_freq_select_strap == ~i_shared_pin);
	endproperty
	a_strap: assert property (p_strap)
		else $error("strap capture or pin turnaround wrong");
	property p_free;
		@(posedge i_clock) disable iff (i_rst)
		o_free_mem_clock == i_mem_buffer_in;
	endproperty
	a_free: assert property (p_free)
		else $error("free memory clock does not follow buffer input");
	c_proc_resume: cover property (@(negedge i_clock) $rose(i_proc_clock_halt_alias_n));
	c_bus_resume: cover property (@(negedge i_bus_clock) $rose(i_bus_clock_halt_n));
	c_ack: cover property (@(posedge i_clock) $fell(o_sda_oe_n));
endmodule
bind clock_gen_control_logic clock_gen_control_logic_chk #(
	.NUM_BUS_CLOCKS(NUM_BUS_CLOCKS),
	.NUM_STRAPS(NUM_STRAPS)
) i_chk (
	.i_clock(i_clock), .i_rst(i_rst), .i_bus_clock(i_bus_clock), .i_scl(i_scl),
	.i_proc_clock_halt_alias_n(i_proc_clock_halt_alias_n),
	.i_bus_clock_halt_n(i_bus_clock_halt_n), .i_mem_buffer_in(i_mem_buffer_in),
	.i_shared_pin(i_shared_pin), .o_sda_oe_n(o_sda_oe_n),
	.o_shared_pin_oe_n(o_shared_pin_oe_n), .o_freq_select_strap(o_freq_select_strap),
	.o_processor_clock_out(o_processor_clock_out),
	.o_intr_ctrl_clock_out(o_intr_ctrl_clock_out), .o_free_mem_clock(o_free_mem_clock),
	.o_gated_bus_clocks(o_gated_bus_clocks)
);

// file: dv/clock_gen_control_logic_tb_top.sv
// self-checking bench: serial block access, halt inputs, power-up straps
// assumes the host model owns the serial link; the bench drives the halt pins
`timescale 1ns/1ps
module clock_gen_control_logic_tb_top;
	logic i_clock = 1'b0;
	logic i_bus_clock = 1'b0;
	logic i_rst = 1'b1;
	logic halt_n = 1'b1;
	logic bus_halt_n = 1'b1;
	logic mem_in = 1'b0;
	logic [4:0] pins = 5'h0b;
	logic scl, host_sda, dut_sda, sda_oe_n, proc, intr, gmem, fmem, fbus;
	logic [4:0] sh_out, sh_oe_n, strap, gbus;
	logic [8:0] rx;
	logic [1:0] free_v;
	logic [7:0] cfg [6];
	int fails = 0;
	int check_count = 0;
	wire sda = host_sda & (sda_oe_n | dut_sda);
	always #4 i_clock = ~i_clock;
	always #6 mem_in = ~mem_in;
	initial begin
		#3;
		forever begin
			i_bus_clock = ~i_bus_clock;
			#16;
		end
	end
	serial_host_model i_host (.i_sda(sda), .o_scl(scl), .o_sda(host_sda));
	clock_gen_control_logic i_dut (.i_clock(i_clock), .i_rst(i_rst), .i_bus_clock(i_bus_clock),
		.i_scl(scl), .i_sda(sda), .o_sda(dut_sda), .o_sda_oe_n(sda_oe_n),
		.i_proc_clock_halt_alias_n(halt_n), .i_bus_clock_halt_n(bus_halt_n),
		.i_mem_buffer_in(mem_in), .i_shared_pin(pins), .i_shared_clock_src(pins ^ {5{mem_in}}),
		.o_shared_pin(sh_out), .o_shared_pin_oe_n(sh_oe_n), .o_freq_select_strap(strap),
		.o_processor_clock_out(proc), .o_intr_ctrl_clock_out(intr), .o_gated_mem_clock(gmem),
		.o_free_mem_clock(fmem), .o_gated_bus_clocks(gbus), .o_free_bus_clock(fbus));
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge i_clock);
		#1;
	endtask
	// or of high phases on bus, processor, interrupt and memory clocks; free clocks apart
	task automatic seen(input int n, output logic [7:0] v);
		v = 8'h00;
		free_v = 2'h0;
		repeat (n) begin
			@(posedge i_clock);
			#2;
			v = v | {gbus, proc, intr, gmem};
			free_v = free_v | {fbus, fmem};
		end
		tick(1);
	endtask
	task automatic write_block(input logic [7:0] d [6], input int n);
		logic [7:0] hdr [3] = '{clock_gen_pkg::WRITE_ADDR, 8'h5a, 8'hf9};
		logic [7:0] b;
		i_host.start();
		for (int i = 0; i < n + 3; i++) begin
			b = (i < 3) ? hdr[i] : d[i - 3];
			i_host.xfer({b, 1'b1}, rx);
			chk("write ack", 8'h00, {7'h0, rx[0]});
			if (i >= 3) begin
				cfg[i - 3] = b;
			end
		end
		i_host.stop();
		tick(1);
	endtask
	task automatic read_block();
		logic [7:0] exp;
		i_host.start();
		i_host.xfer({clock_gen_pkg::READ_ADDR, 1'b1}, rx);
		chk("read address ack", 8'h00, {7'h0, rx[0]});
		for (int i = 0; i < 8; i++) begin
			exp = (i == 0) ? clock_gen_pkg::BYTE_COUNT_VALUE : clock_gen_pkg::FILLER_BYTE;
			if (i > 0 && i < 7) begin
				exp = cfg[i - 1];
			end
			i_host.xfer({8'hff, i == 7}, rx);
			chk("read byte", exp, rx[8:1]);
		end
		i_host.stop();
		tick(1);
	endtask
	task automatic t_power_up();
		chk("strap", {3'h0, ~pins}, {3'h0, strap});
		chk("pin mode", 8'h00, {3'h0, sh_oe_n});
		chk("pin drive", {3'h0, pins ^ {5{mem_in}}}, {3'h0, sh_out});
		read_block();
		$display("power-up test done");
	endtask
	task automatic t_write();
		logic [7:0] v;
		write_block('{8'hff, 8'h05, 8'ha1, 8'hb2, 8'hc3, 8'hd4}, 6);
		read_block();
		seen(16, v);
		chk("enabled clocks", 8'hfd, v);
		$display("block write test done");
	endtask
	task automatic t_partial();
		logic [7:0] v;
		write_block('{8'hff, 8'h07, 8'h5a, 8'h00, 8'h00, 8'h00}, 3);
		read_block();
		seen(16, v);
		chk("enabled clocks", 8'hff, v);
		$display("partial write test done");
	endtask
	task automatic t_foreign();
		i_host.start();
		i_host.xfer(9'h141, rx);
		chk("foreign ack", 8'h01, {7'h0, rx[0]});
		i_host.xfer(9'h1ff, rx);
		chk("line released", 8'hff, rx[8:1]);
		i_host.stop();
		tick(1);
		read_block();
		$display("foreign address test done");
	endtask
	task automatic t_proc_halt();
		logic [7:0] v;
		halt_n = 1'b0;
		tick(5);
		seen(24, v);
		chk("halted clocks", 8'hf8, v);
		chk("free clocks", 8'h03, {6'h0, free_v});
		halt_n = 1'b1;
		tick(5);
		seen(16, v);
		chk("resumed clocks", 8'hff, v);
		tick(100);
		$display("processor halt test done");
	endtask
	task automatic t_bus_halt();
		logic [7:0] v;
		bus_halt_n = 1'b0;
		tick(16);
		seen(24, v);
		chk("bus halted", 8'h07, v);
		chk("free clocks", 8'h03, {6'h0, free_v});
		bus_halt_n = 1'b1;
		tick(16);
		seen(16, v);
		chk("bus resumed", 8'hff, v);
		tick(40);
		$display("bus halt test done");
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		#400000;
		fails++;
		$display("Error watchdog expected done seen hang");
		stop_test();
	end
	initial begin
		foreach (cfg[i]) begin
			cfg[i] = clock_gen_pkg::CFG_DEFAULT;
		end
		tick(10);
		i_rst = 1'b0;
		tick(4);
		t_power_up();
		t_write();
		t_partial();
		t_foreign();
		t_proc_halt();
		t_bus_halt();
		stop_test();
	end
endmodule
